// ### rtl/nocr_pkg.sv
package nocr_pkg;
	// register indices; bus byte address is four times the index
	localparam logic [13:0] IDX_CAUSE = 14'h0015;
	localparam logic [13:0] IDX_MASK = 14'h0016;
	localparam logic [13:0] IDX_RTP_HI = 14'h0017;
	localparam logic [13:0] IDX_RTP_LO = 14'h0018;
	localparam logic [13:0] IDX_RLIMIT = 14'h0019;
	localparam logic [13:0] IDX_RXSPLIT = 14'h001a;
	localparam logic [13:0] IDX_TXSPLIT = 14'h001b;
	localparam logic [13:0] IDX_AUTH_HI = 14'h001c;
	localparam logic [13:0] IDX_AUTH_LO = 14'h001d;
	localparam logic [13:0] IDX_ECHO = 14'h0028;
	localparam logic [13:0] IDX_MAGIC = 14'h0029;
	localparam logic [13:0] IDX_UIP0 = 14'h002a;
	localparam logic [13:0] IDX_UNREACHABLE_DEST_PORT_HI = 14'h002e;
	localparam logic [13:0] IDX_UNREACHABLE_DEST_PORT_LO = 14'h002f;
	localparam logic [5:0] SOCK_PAGE_FIRST = 6'h04;
	localparam logic [5:0] SOCK_PAGE_LAST = 6'h07;
	localparam logic [7:0] SOCK_MODE_OFS = 8'h00;
	localparam logic [7:0] SOCK_FLAGS_OFS = 8'h02;
	// reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [15:0] RTP_RESET = 16'h07d0;
	localparam logic [7:0] RLIMIT_RESET = 8'h08;
	localparam logic [7:0] SPLIT_RESET = 8'h55;
	localparam logic [15:0] AUTH_RESET = 16'h0000;
	localparam logic [7:0] ECHO_RESET = 8'h28;
	localparam logic [7:0] MAGIC_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// field positions
	localparam int MASK_RSVD_BIT = 4;
	localparam int MODE_MULTI_BIT = 7;
	localparam int MODE_ACKMC_BIT = 5;
	localparam int FLAG_TIMEOUT_BIT = 3;
	// protocol codes
	localparam logic [3:0] PROTO_CLOSED = 4'h0;
	localparam logic [3:0] PROTO_TCP = 4'h1;
	localparam logic [3:0] PROTO_UDP = 4'h2;
	localparam logic [3:0] PROTO_IPRAW = 4'h3;
	localparam logic [3:0] PROTO_MACRAW = 4'h4;
	localparam logic [3:0] PROTO_PPPOE = 4'h5;
	// buffer memory
	localparam logic [14:0] BUF_TOTAL = 15'h2000;
	localparam logic [14:0] BUF_UNIT = 15'h0400;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RETRY_TICK_NS = 100000;
	localparam int ECHO_TICK_NS = 25000000;
	localparam int RETRY_TICK_CYCLES = RETRY_TICK_NS * 1000 / CLK_PERIOD_PS;
	localparam int ECHO_TICK_CYCLES = ECHO_TICK_NS / (CLK_PERIOD_PS / 1000);
	localparam int PRE_W = 15;
	localparam int ECHO_W = 23;
endpackage : nocr_pkg

// ### rtl/nocr_regs.sv
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module nocr_regs import nocr_pkg::*; #(
	parameter int RETRY_TICK = RETRY_TICK_CYCLES,
	parameter int ECHO_TICK = ECHO_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// events from the protocol engines
	input wire logic ip_clash_event,
	input wire logic ppp_close_event,
	input wire logic unreach_event,
	input wire logic [31:0] unreach_ip_in,
	input wire logic [15:0] unreach_port_in,
	input wire logic auth_load,
	input wire logic [15:0] auth_value_in,
	input wire logic [19:0] sock_event_set,
	// retry timers
	input wire logic [3:0] transmit_start,
	input wire logic [3:0] peer_response,
	output logic [3:0] retransmit_req,
	// ppp keepalive
	input wire logic ppp_link_up,
	output logic lcp_echo_due,
	output logic [7:0] lcp_magic_value,
	// socket configuration
	output logic [31:0] socket_mode,
	output logic [3:0] multicast_enable,
	output logic [3:0] immediate_ack,
	output logic [3:0] igmp_ver1,
	output logic [3:0] proto_legal,
	output logic [55:0] rx_base,
	output logic [55:0] rx_size,
	output logic [55:0] tx_base,
	output logic [55:0] tx_size,
	// interrupt
	output logic int_n
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] mask;
		logic [2:0] glob;
		logic [15:0] rtp;
		logic [7:0] rlimit;
		logic [7:0] rxsplit;
		logic [7:0] txsplit;
		logic [15:0] auth;
		logic [7:0] echo_int;
		logic [7:0] magic;
		logic [31:0] uip;
		logic [15:0] unreachable_dest_port;
		logic [3:0][7:0] mode;
		logic [3:0][4:0] sflags;
		logic [PRE_W-1:0] pre;
		logic [3:0] active;
		logic [3:0][15:0] ticks;
		logic [3:0][7:0] retries;
		logic [3:0] retx;
		logic [ECHO_W-1:0] echo_pre;
		logic [7:0] echo_cnt;
		logic echo_due;
		logic [3:0] mcast;
		logic [3:0] imm_ack;
		logic [3:0] igmp1;
		logic [3:0] legal;
		logic [3:0][13:0] rxb;
		logic [3:0][13:0] rxs;
		logic [3:0][13:0] txb;
		logic [3:0][13:0] txs;
		logic int_n;
	} nocr_state_type;

	nocr_state_type state;
	nocr_state_type next_state;

	logic [13:0] idx;
	logic [5:0] page;
	logic [7:0] pofs;
	logic req;
	logic wr_commit;
	logic [7:0] wbyte;
	logic [7:0] cause;
	logic [7:0] rbyte;
	logic pre_tick;
	logic echo_tick;

	assign idx = adr_i[15:2];
	assign page = idx[13:8];
	assign pofs = idx[7:0];
	assign req = cyc_i & stb_i;
	// a write lands on the edge where the master sees ack
	assign wr_commit = req & we_i & state.ack & sel_i[0];
	assign wbyte = dat_i[7:0];
	assign pre_tick = (state.pre == PRE_W'(RETRY_TICK - 1));
	assign echo_tick = (state.echo_pre == ECHO_W'(ECHO_TICK - 1));

	always_comb begin
		logic [14:0] racc;
		logic [14:0] tacc;
		logic [14:0] sz;
		logic [3:0] sock_any;
		logic [3:0] p;
		int s;
		racc = '0;
		tacc = '0;
		sz = '0;
		sock_any = '0;
		p = '0;
		s = 0;
		next_state = state;
		// classic wishbone: ack one cycle after request, dropped next cycle
		next_state.ack = req & ~state.ack;
		// free-running prescalers
		next_state.pre = pre_tick ? '0 : state.pre + 1'b1;
		next_state.echo_pre = echo_tick ? '0 : state.echo_pre + 1'b1;
		// register writes
		if (wr_commit) begin
			if (idx == IDX_CAUSE) begin
				next_state.glob = state.glob & ~wbyte[7:5];
			end else if (idx == IDX_MASK) begin
				next_state.mask = wbyte;
				next_state.mask[MASK_RSVD_BIT] = 1'b0;
			end else if (idx == IDX_RTP_HI) begin
				next_state.rtp[15:8] = wbyte;
			end else if (idx == IDX_RTP_LO) begin
				next_state.rtp[7:0] = wbyte;
			end else if (idx == IDX_RLIMIT) begin
				next_state.rlimit = wbyte;
			end else if (idx == IDX_RXSPLIT) begin
				next_state.rxsplit = wbyte;
			end else if (idx == IDX_TXSPLIT) begin
				next_state.txsplit = wbyte;
			end else if (idx == IDX_ECHO) begin
				next_state.echo_int = wbyte;
			end else if (idx == IDX_MAGIC) begin
				next_state.magic = wbyte;
			end else if (page >= SOCK_PAGE_FIRST && page <= SOCK_PAGE_LAST) begin
				s = int'(page[1:0]);
				if (pofs == SOCK_MODE_OFS) begin
					next_state.mode[s] = wbyte;
				end else if (pofs == SOCK_FLAGS_OFS) begin
					next_state.sflags[s] = state.sflags[s] & ~wbyte[4:0];
				end
			end
		end
		// hardware sets win over software clears
		if (ip_clash_event) begin
			next_state.glob[2] = 1'b1;
		end
		if (unreach_event) begin
			next_state.glob[1] = 1'b1;
			next_state.uip = unreach_ip_in;
			next_state.unreachable_dest_port = unreach_port_in;
		end
		if (ppp_close_event) begin
			next_state.glob[0] = 1'b1;
		end
		if (auth_load) begin
			next_state.auth = auth_value_in;
		end
		// retry timers, one per socket
		for (int i = 0; i < 4; i++) begin
			next_state.retx[i] = 1'b0;
			next_state.sflags[i] = next_state.sflags[i] | sock_event_set[i*5 +: 5];
			if (transmit_start[i]) begin
				next_state.active[i] = 1'b1;
				next_state.ticks[i] = '0;
				next_state.retries[i] = '0;
			end else if (peer_response[i]) begin
				next_state.active[i] = 1'b0;
			end else if (state.active[i] && pre_tick) begin
				if (state.ticks[i] + 16'h0001 >= state.rtp) begin
					next_state.ticks[i] = '0;
					if (state.retries[i] >= state.rlimit) begin
						// limit already used up: this expiry is one too many
						next_state.active[i] = 1'b0;
						next_state.sflags[i][FLAG_TIMEOUT_BIT] = 1'b1;
					end else begin
						next_state.retries[i] = state.retries[i] + 8'h01;
						next_state.retx[i] = 1'b1;
					end
				end else begin
					next_state.ticks[i] = state.ticks[i] + 16'h0001;
				end
			end
		end
		// lcp echo pacing, only while the ppp link is up
		next_state.echo_due = 1'b0;
		if (!ppp_link_up) begin
			next_state.echo_cnt = '0;
		end else if (echo_tick) begin
			if (state.echo_cnt + 8'h01 >= state.echo_int) begin
				next_state.echo_cnt = '0;
				next_state.echo_due = 1'b1;
			end else begin
				next_state.echo_cnt = state.echo_cnt + 8'h01;
			end
		end
		// buffer carving in socket order; a socket that does not fit gets 0
		for (int i = 0; i < 4; i++) begin
			sz = BUF_UNIT << state.rxsplit[i*2 +: 2];
			if (racc + sz <= BUF_TOTAL) begin
				next_state.rxb[i] = racc[13:0];
				next_state.rxs[i] = sz[13:0];
				racc = racc + sz;
			end else begin
				next_state.rxb[i] = '0;
				next_state.rxs[i] = '0;
				racc = BUF_TOTAL;
			end
			sz = BUF_UNIT << state.txsplit[i*2 +: 2];
			if (tacc + sz <= BUF_TOTAL) begin
				next_state.txb[i] = tacc[13:0];
				next_state.txs[i] = sz[13:0];
				tacc = tacc + sz;
			end else begin
				next_state.txb[i] = '0;
				next_state.txs[i] = '0;
				tacc = BUF_TOTAL;
			end
		end
		// socket mode decode
		for (int i = 0; i < 4; i++) begin
			p = state.mode[i][3:0];
			next_state.mcast[i] = (p == PROTO_UDP) &
				state.mode[i][MODE_MULTI_BIT];
			next_state.imm_ack[i] = (p == PROTO_TCP) &
				state.mode[i][MODE_ACKMC_BIT];
			next_state.igmp1[i] = next_state.mcast[i] &
				state.mode[i][MODE_ACKMC_BIT];
			if (p == PROTO_CLOSED || p == PROTO_TCP) begin
				next_state.legal[i] = 1'b1;
			end else if (p == PROTO_UDP || p == PROTO_IPRAW) begin
				next_state.legal[i] = 1'b1;
			end else if (p == PROTO_MACRAW || p == PROTO_PPPOE) begin
				next_state.legal[i] = (i == 0);
			end else begin
				next_state.legal[i] = 1'b0;
			end
		end
		// interrupt level follows the registered flags and mask
		for (int i = 0; i < 4; i++) begin
			sock_any[i] = |next_state.sflags[i];
		end
		next_state.int_n = ~|({next_state.glob, 1'b0, sock_any} &
			next_state.mask);
		// read data captured in the request cycle
		if (req && !state.ack) begin
			next_state.rdata = {24'h000000, rbyte};
		end
	end

	// read mux; unmapped indices read zero
	always_comb begin
		int s;
		s = int'(page[1:0]);
		cause = {state.glob, 1'b0, |state.sflags[3], |state.sflags[2],
			|state.sflags[1], |state.sflags[0]};
		if (idx == IDX_CAUSE) begin
			rbyte = cause;
		end else if (idx == IDX_MASK) begin
			rbyte = state.mask;
		end else if (idx == IDX_RTP_HI) begin
			rbyte = state.rtp[15:8];
		end else if (idx == IDX_RTP_LO) begin
			rbyte = state.rtp[7:0];
		end else if (idx == IDX_RLIMIT) begin
			rbyte = state.rlimit;
		end else if (idx == IDX_RXSPLIT) begin
			rbyte = state.rxsplit;
		end else if (idx == IDX_TXSPLIT) begin
			rbyte = state.txsplit;
		end else if (idx == IDX_AUTH_HI) begin
			rbyte = state.auth[15:8];
		end else if (idx == IDX_AUTH_LO) begin
			rbyte = state.auth[7:0];
		end else if (idx == IDX_ECHO) begin
			rbyte = state.echo_int;
		end else if (idx == IDX_MAGIC) begin
			rbyte = state.magic;
		end else if (idx >= IDX_UIP0 && idx <= IDX_UIP0 + 14'h0003) begin
			rbyte = state.uip[(3 - int'(idx[1:0] ^ IDX_UIP0[1:0]))*8 +: 8];
		end else if (idx == IDX_UNREACHABLE_DEST_PORT_HI) begin
			rbyte = state.unreachable_dest_port[15:8];
		end else if (idx == IDX_UNREACHABLE_DEST_PORT_LO) begin
			rbyte = state.unreachable_dest_port[7:0];
		end else if (page >= SOCK_PAGE_FIRST && page <= SOCK_PAGE_LAST &&
			pofs == SOCK_MODE_OFS) begin
			rbyte = state.mode[s];
		end else if (page >= SOCK_PAGE_FIRST && page <= SOCK_PAGE_LAST &&
			pofs == SOCK_FLAGS_OFS) begin
			rbyte = {3'b000, state.sflags[s]};
		end else begin
			rbyte = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
			state.mask <= MASK_RESET;
			state.rtp <= RTP_RESET;
			state.rlimit <= RLIMIT_RESET;
			state.rxsplit <= SPLIT_RESET;
			state.txsplit <= SPLIT_RESET;
			state.auth <= AUTH_RESET;
			state.echo_int <= ECHO_RESET;
			state.magic <= MAGIC_RESET;
			state.mode <= {4{MODE_RESET}};
			state.int_n <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign dat_o = state.rdata;
	assign ack_o = state.ack;
	assign retransmit_req = state.retx;
	assign lcp_echo_due = state.echo_due;
	assign lcp_magic_value = state.magic;
	assign socket_mode = state.mode;
	assign multicast_enable = state.mcast;
	assign immediate_ack = state.imm_ack;
	assign igmp_ver1 = state.igmp1;
	assign proto_legal = state.legal;
	assign rx_base = state.rxb;
	assign rx_size = state.rxs;
	assign tx_base = state.txb;
	assign tx_size = state.txs;
	assign int_n = state.int_n;

endmodule : nocr_regs

// ### verification/nocr_regs_properties.sv
`timescale 1ns/1ps
module nocr_regs_properties import nocr_pkg::*; (
	// bus
	input wire logic clk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// retry
	input wire logic [3:0] transmit_start,
	input wire logic [3:0] peer_response,
	input wire logic [3:0] retransmit_req,
	// socket setup
	input wire logic [31:0] socket_mode,
	input wire logic [3:0] multicast_enable,
	input wire logic [3:0] immediate_ack,
	input wire logic [3:0] proto_legal,
	input wire logic [55:0] rx_base,
	input wire logic [55:0] rx_size
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	// socket 1 mode write, seen at its acknowledging edge
	sequence s_mwr;
		cyc_i && stb_i && we_i && sel_i[0] && ack_o &&
			adr_i[15:2] == {SOCK_PAGE_FIRST + 6'h01, SOCK_MODE_OFS};
	endsequence
	property p_ack; s_req |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("request not acked");
	property p_ack1; ack_o |=> !ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
	property p_mode; s_mwr |=> socket_mode[15:8] == $past(dat_i[7:0]); endproperty
	a_mode: assert property (p_mode) else $error("mode write lost");
	// decodes lag the mode by a cycle, so skip the edge leaving reset
	property p_legal;
		!$past(reset) |-> proto_legal[1] == ($past(socket_mode[11:8]) <= 4'h3);
	endproperty
	a_legal: assert property (p_legal) else $error("bad legal");
	property p_mcast;
		!$past(reset) |-> multicast_enable[1] == ($past(socket_mode[15]) &&
			$past(socket_mode[11:8]) == PROTO_UDP);
	endproperty
	a_mcast: assert property (p_mcast) else $error("bad multicast");
	property p_nd;
		!$past(reset) |-> immediate_ack[0] == ($past(socket_mode[5]) &&
			$past(socket_mode[3:0]) == PROTO_TCP);
	endproperty
	a_nd: assert property (p_nd) else $error("bad ack option");
	property p_base;
		rx_size[27:14] != 14'h0 |-> rx_base[27:14] == rx_size[13:0];
	endproperty
	a_base: assert property (p_base) else $error("bad base");
	property p_stop;
		peer_response[0] && !transmit_start[0] |=> ##1 !retransmit_req[0] [*7];
	endproperty
	a_stop: assert property (p_stop) else $error("retry after answer");
endmodule : nocr_regs_properties
bind nocr_regs nocr_regs_properties u_props (.clk(clk), .reset(reset),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .ack_o(ack_o), .transmit_start(transmit_start),
	.peer_response(peer_response), .retransmit_req(retransmit_req),
	.socket_mode(socket_mode), .multicast_enable(multicast_enable),
	.immediate_ack(immediate_ack), .proto_legal(proto_legal),
	.rx_base(rx_base), .rx_size(rx_size));

// ### verification/nocr_host.sv
`timescale 1ns/1ps
module nocr_host import nocr_pkg::*; (
	// clock
	input wire logic clk,
	// wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [15:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat,
	input wire logic [31:0] rdat,
	input wire logic ack,
	// a bus wait ran out
	output logic tmo
);
	initial {cyc, stb, we, adr, sel, dat, tmo} = '0;
	task automatic xfer(input logic w, input logic [13:0] idx,
		input logic [7:0] d, output logic [7:0] r);
		int n;
		if (w && idx == IDX_MASK) d[MASK_RSVD_BIT] = 1'b0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'h1;
		dat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 32);
		r = rdat[7:0];
		if (n >= 32) tmo <= 1'b1;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : xfer
endmodule : nocr_host

// ### verification/net_offload_common_config_regs_tb.sv
`timescale 1ns/1ps
module net_offload_common_config_regs_tb import nocr_pkg::*; ;
	logic clk, reset, cyc, stb, we, ack, int_n, tmo, link, auth_load, echo;
	logic [15:0] adr, unreachable_dest_port, auth_in;
	logic [3:0] sel, tx_start, peer, rreq, mc, nd, ig, legal;
	logic [31:0] dat, rdat, uip, mode;
	logic [55:0] rxb, rxs, txb, txs;
	logic [7:0] magic, q, d, s;
	logic [13:0] sz;
	logic [2:0] ev;
	logic [19:0] sev;
	int err_count = 0;
	int check_count = 0;
	int seed = 32'h697708a3;
	int rcnt = 0;
	int ecnt = 0;
	int cyc_n = 0;
	int last_rt = 0;
	int gap = 0;
	int cum;
	logic [13:0] ridx [12] = '{IDX_MASK, IDX_RTP_HI, IDX_RTP_LO, IDX_RLIMIT,
		IDX_RXSPLIT, IDX_TXSPLIT, IDX_AUTH_HI, IDX_ECHO, IDX_MAGIC, IDX_UIP0,
		IDX_UNREACHABLE_DEST_PORT_HI, 14'h0700};
	logic [7:0] rval [12] = '{MASK_RESET, RTP_RESET[15:8], RTP_RESET[7:0],
		RLIMIT_RESET, SPLIT_RESET, SPLIT_RESET, AUTH_RESET[15:8], ECHO_RESET,
		MAGIC_RESET, 8'h00, 8'h00, MODE_RESET};
	// short ticks keep retry and echo runs to tens of cycles
	nocr_regs #(.RETRY_TICK(4), .ECHO_TICK(8)) dut (.clk(clk), .reset(reset),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dat), .dat_o(rdat), .ack_o(ack), .ip_clash_event(ev[2]),
		.ppp_close_event(ev[0]), .unreach_event(ev[1]), .unreach_ip_in(uip),
		.unreach_port_in(unreachable_dest_port), .auth_load(auth_load), .auth_value_in(auth_in),
		.sock_event_set(sev), .transmit_start(tx_start), .peer_response(peer),
		.retransmit_req(rreq), .ppp_link_up(link), .lcp_echo_due(echo),
		.lcp_magic_value(magic), .socket_mode(mode), .multicast_enable(mc),
		.immediate_ack(nd), .igmp_ver1(ig), .proto_legal(legal), .rx_base(rxb),
		.rx_size(rxs), .tx_base(txb), .tx_size(txs), .int_n(int_n));
	nocr_host h (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(dat), .rdat(rdat), .ack(ack), .tmo(tmo));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// counted mid-cycle so a window opened on a rising edge has no race
	always @(negedge clk) begin
		cyc_n++;
		if (|rreq === 1'b1) begin
			rcnt++;
			gap = cyc_n - last_rt;
			last_rt = cyc_n;
		end
		if (echo === 1'b1) ecnt++;
	end
	always @(posedge tmo) begin
		err_count++;
		print_verdict();
	end
	function automatic logic okp(input int n, input logic [3:0] c);
		return c <= PROTO_IPRAW || (n == 0 && c <= PROTO_PPPOE);
	endfunction : okp
	function automatic logic [7:0] rwexp(input int i, input logic [7:0] v);
		if (i == 6 || i == 9 || i == 10) return rval[i];
		return i == 0 ? v & 8'hef : v;
	endfunction : rwexp
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [13:0] i, input logic [7:0] v);
		h.xfer(1'b1, i, v, q);
	endtask : wr
	task automatic rc(input logic [13:0] i, input logic [7:0] e, input string nm);
		h.xfer(1'b0, i, 8'h00, q);
		chk(nm, {24'h0, e}, {24'h0, q});
	endtask : rc
	task automatic wt(input logic v, input string nm);
		int n;
		n = 0;
		while (int_n !== v && n < 8) begin
			@(posedge clk);
			n++;
		end
		chk(nm, {31'h0, v}, {31'h0, int_n});
		if (n >= 8) print_verdict();
	endtask : wt
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		reset = 1'b1;
		{ev, sev, uip, unreachable_dest_port, auth_load, auth_in, tx_start, peer, link} = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 12; i++) rc(ridx[i], rval[i], "reset");
		$display("test reset values done");
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			wr(ridx[i], d);
			rc(ridx[i], rwexp(i, d), "rw");
			if (i == 8) chk("magic", {24'h0, d}, {24'h0, magic});
		end
		rc(14'h0030, 8'h00, "unmapped");
		$display("test access done");
		for (int t = 0; t < 10; t++) begin
			d = t == 0 ? 8'haa : t == 1 ? 8'hff : 8'($random(seed));
			wr(IDX_RXSPLIT, d);
			wr(IDX_TXSPLIT, ~d);
			repeat (2) @(posedge clk);
			for (int k = 0; k < 2; k++) begin
				s = k ? ~d : d;
				cum = 0;
				for (int n = 0; n < 4; n++) begin
					sz = 14'h400 << s[2*n +: 2];
					if (cum + sz <= 8192) begin
						chk("size", sz, k ? txs[14*n +: 14] : rxs[14*n +: 14]);
						chk("base", cum, k ? txb[14*n +: 14] : rxb[14*n +: 14]);
						cum += sz;
					end else begin
						chk("no space", 0, k ? txs[14*n +: 14] : rxs[14*n +: 14]);
						// once one socket misses, every later one is shut out
						cum = 8192;
					end
				end
			end
		end
		$display("test buffer split done");
		for (int n = 0; n < 4; n++) for (int c = 0; c < 16; c++) begin
			d = $random(seed);
			d[3:0] = c[3:0];
			wr({SOCK_PAGE_FIRST + n[5:0], SOCK_MODE_OFS}, d);
			repeat (2) @(posedge clk);
			chk("mode", d, mode[8*n +: 8]);
			chk("legal", okp(n, d[3:0]), legal[n]);
			chk("mcast", d[7] && d[3:0] == PROTO_UDP, mc[n]);
			chk("nd", d[5] && d[3:0] == PROTO_TCP, nd[n]);
			chk("igmp", d[7] && d[5] && d[3:0] == PROTO_UDP, ig[n]);
		end
		$display("test socket mode done");
		for (int i = 0; i < 3; i++) begin
			d = 8'h20 << i;
			uip <= $random(seed);
			unreachable_dest_port <= 16'($random(seed));
			wr(IDX_MASK, 8'h00);
			ev[i] <= 1'b1;
			@(posedge clk) ev[i] <= 1'b0;
			repeat (3) @(posedge clk);
			chk("int masked", 1, int_n);
			rc(IDX_CAUSE, d, "cause");
			if (i == 1) for (int b = 0; b < 6; b++) rc(IDX_UIP0 + 14'(b),
				b < 4 ? uip[31-8*b -: 8] : unreachable_dest_port[47-8*b -: 8], "unreach");
			wr(IDX_MASK, d);
			wt(1'b0, "int set");
			wr(IDX_CAUSE, d);
			wt(1'b1, "int clear");
		end
		for (int n = 0; n < 4; n++) begin
			d = 8'h01 << n;
			wr(IDX_MASK, d);
			sev <= 20'h4 << (5 * n);
			@(posedge clk) sev <= '0;
			rc(IDX_CAUSE, d, "sock cause");
			wt(1'b0, "sev int set");
			wr({SOCK_PAGE_FIRST + 6'(n), SOCK_FLAGS_OFS}, 8'h04);
			wt(1'b1, "sev int clear");
		end
		for (int i = 0; i < 2; i++) begin
			auth_in <= i ? 16'hc223 : 16'hc023;
			auth_load <= 1'b1;
			@(posedge clk) auth_load <= 1'b0;
			rc(IDX_AUTH_HI, auth_in[15:8], "auth hi");
			rc(IDX_AUTH_LO, auth_in[7:0], "auth lo");
		end
		$display("test events done");
		wr(IDX_RTP_HI, 8'h00);
		wr(IDX_RTP_LO, 8'h01);
		wr(IDX_RLIMIT, 8'h01);
		wr(IDX_MASK, 8'h02);
		tx_start <= 4'h2;
		@(posedge clk) tx_start <= 4'h0;
		cum = rcnt;
		repeat (60) @(posedge clk);
		chk("retries", 1, rcnt - cum);
		rc({6'h05, SOCK_FLAGS_OFS}, 8'h08, "timeout flag");
		wt(1'b0, "sock int");
		wr({6'h05, SOCK_FLAGS_OFS}, 8'h08);
		wt(1'b1, "sock int clear");
		wr(IDX_RTP_LO, 8'h02);
		wr(IDX_RLIMIT, 8'h02);
		tx_start <= 4'h4;
		@(posedge clk) tx_start <= 4'h0;
		cum = rcnt;
		repeat (60) @(posedge clk);
		chk("retries 2", 2, rcnt - cum);
		chk("period", 8, gap);
		rc({6'h06, SOCK_FLAGS_OFS}, 8'h08, "timeout 2");
		chk("int masked 2", 1, int_n);
		wr(IDX_RTP_LO, 8'h05);
		tx_start <= 4'h1;
		@(posedge clk) tx_start <= 4'h0;
		peer <= 4'h1;
		@(posedge clk) peer <= 4'h0;
		cum = rcnt;
		repeat (40) @(posedge clk);
		chk("stopped", 0, rcnt - cum);
		$display("test retry done");
		wr(IDX_ECHO, 8'h01);
		link <= 1'b1;
		repeat (4) @(posedge clk);
		cum = ecnt;
		repeat (40) @(posedge clk);
		chk("echo", 5, ecnt - cum);
		$display("test echo done");
		print_verdict();
	end
endmodule : net_offload_common_config_regs_tb
